// file: common/pmie_defs.svh
// Opcode, field and reset constants for the move instruction executor
// Overview of operation
// [RL1] Move to bidir_port_two copies the addressed RAM nibble to its latch in one cycle
// [RL2] Move to high_sink_output_port copies the addressed RAM nibble in one cycle
// [RL3] System clock select writes act only when dual-clock option is chosen
// [RL4] Clock select bit 0: clear picks main_osc_freq, set picks sub_osc_freq
// [RL5] Clock select bit 1: clear runs main oscillator, set stops it
// [RL6] Clock select bit 3: divider 1 is 14-stage when clear, 13-stage when set
// [RL7] Wake-enable instruction loads per-pin falling-edge wake mask from its immediate
// [RL8] Timer zero immediate set loads eight bits and starts timer zero
// [RL9] Timer one immediate set loads eight bits and starts timer one
// [RL10] Timer zero low preset takes the addressed RAM nibble in one cycle
// [RL11] Timer zero high preset takes the addressed RAM nibble in one cycle
// [RL12] Timer zero high move decodes by fixed nine-bit prefix plus address field
// [RL13] Timer one low preset takes the addressed RAM nibble in one cycle
// [RL14] Seven-bit direct address field reaches any data RAM location
// [RL15] Each timer preset joins high nibble above low nibble into eight bits; timer one preset here keeps its high nibble at zero
`ifndef PMIE_DEFS_SVH
`define PMIE_DEFS_SVH
`define PMIE_OP_HI          15
`define PMIE_PFX_LO         7
`define PMIE_IMM8_HI        7
`define PMIE_IMM8_PFX_LO    8
`define PMIE_IMM4_PFX_LO    4
`define PMIE_IMM4_HI        3
`define PMIE_PFX_BIDIR2     9'h0b5
`define PMIE_PFX_HSINK      9'h0b8
`define PMIE_PFX_SCS        9'h0a0
`define PMIE_PFX_T0L        9'h028
`define PMIE_PFX_T0H        9'h029
`define PMIE_PFX_T1L        9'h02a
`define PMIE_PFX_WAKE       12'h410
`define PMIE_PFX_T0IMM      8'h10
`define PMIE_PFX_T1IMM      8'h11
`define PMIE_SCS_SUB_BIT    0
`define PMIE_SCS_STOP_BIT   1
`define PMIE_SCS_DIV13_BIT  3
`define PMIE_RST_NIB        4'h0
`define PMIE_RST_SCS        4'h0
`define PMIE_RST_BYTE       8'h00
`define PMIE_RAM_DEPTH      128
`endif

// file: common/pmie_pkg.sv
// Types shared by the move instruction executor
package pmie_pkg;
  typedef logic [3:0]  pmie_nib_t;
  typedef logic [6:0]  pmie_addr_t;
  typedef logic [7:0]  pmie_byte_t;
  typedef logic [15:0] pmie_instr_t;
  typedef enum logic [3:0] {
    PMIE_OP_NONE,
    PMIE_OP_BIDIR2,
    PMIE_OP_HSINK,
    PMIE_OP_SCS,
    PMIE_OP_WAKE,
    PMIE_OP_T0IMM,
    PMIE_OP_T1IMM,
    PMIE_OP_T0L,
    PMIE_OP_T0H,
    PMIE_OP_T1L
  } pmie_op_t;
endpackage

// file: rtl/pmie_dmem.sv
// Data RAM, 128 nibbles, one write port and one asynchronous read port
`timescale 1ns/1ps
`include "pmie_defs.svh"
module pmie_dmem (
  input  wire logic                 i_clk,
  input  wire logic                 i_we,
  input  wire pmie_pkg::pmie_addr_t i_waddr,
  input  wire pmie_pkg::pmie_nib_t  i_wdata,
  input  wire pmie_pkg::pmie_addr_t i_raddr,
  output pmie_pkg::pmie_nib_t       o_rdata
);
  import pmie_pkg::*;
  // No reset on contents: RAM is undefined at power-up, as in the core
  pmie_nib_t mem_r [`PMIE_RAM_DEPTH];
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end
  // Full 7-bit index, every location reachable
  assign o_rdata = mem_r[i_raddr]; // RL14
endmodule // pmie_dmem

// file: rtl/pmie_top.sv
// Executor for port, clock-select, wake-enable and timer move instructions
`timescale 1ns/1ps
`include "pmie_defs.svh"
module pmie_top (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_instr_valid,
  input  wire pmie_pkg::pmie_instr_t i_instr,
  input  wire logic                  i_dual_clock_opt,
  input  wire logic                  i_ram_we,
  input  wire pmie_pkg::pmie_addr_t  i_ram_waddr,
  input  wire pmie_pkg::pmie_nib_t   i_ram_wdata,
  output pmie_pkg::pmie_nib_t        o_bidir_port_two,
  output pmie_pkg::pmie_nib_t        o_high_sink_output_port,
  output logic                       o_sub_osc_sel,
  output logic                       o_main_osc_stop,
  output logic                       o_div1_13_stage,
  output pmie_pkg::pmie_nib_t        o_stop_wake_enable_mask,
  output logic                       o_timer_zero_start,
  output pmie_pkg::pmie_byte_t       o_timer_zero_load,
  output logic                       o_timer_one_start,
  output pmie_pkg::pmie_byte_t       o_timer_one_load,
  output pmie_pkg::pmie_byte_t       o_timer_zero_preset,
  output pmie_pkg::pmie_byte_t       o_timer_one_preset
);
  import pmie_pkg::*;

  pmie_op_t   op;
  pmie_addr_t src_addr;
  pmie_nib_t  src_nib;
  logic [8:0] pfx9;

  pmie_nib_t  bidir_r, bidir_nxt;
  pmie_nib_t  hsink_r, hsink_nxt;
  pmie_nib_t  scs_r, scs_nxt;
  pmie_nib_t  wake_r, wake_nxt;
  logic       t0_start_r, t0_start_nxt;
  logic       t1_start_r, t1_start_nxt;
  pmie_byte_t t0_load_r, t0_load_nxt;
  pmie_byte_t t1_load_r, t1_load_nxt;
  pmie_nib_t  t0_lo_r, t0_lo_nxt;
  pmie_nib_t  t0_hi_r, t0_hi_nxt;
  pmie_nib_t  t1_lo_r, t1_lo_nxt;
  pmie_byte_t t0_pre_r, t0_pre_nxt;
  pmie_byte_t t1_pre_r, t1_pre_nxt;

  assign pfx9     = i_instr[`PMIE_OP_HI:`PMIE_PFX_LO];
  assign src_addr = i_instr[`PMIE_PFX_LO-1:0]; // RL14

  pmie_dmem u_dmem (
    .i_clk   (i_clk),
    .i_we    (i_ram_we),
    .i_waddr (i_ram_waddr),
    .i_wdata (i_ram_wdata),
    .i_raddr (src_addr),
    .o_rdata (src_nib)
  );

  // Opcode decode; prefixes are disjoint so order does not matter
  always_comb begin
    op = PMIE_OP_NONE;
    if (i_instr_valid) begin
      if (pfx9 == `PMIE_PFX_BIDIR2) begin
        op = PMIE_OP_BIDIR2;
      end else if (pfx9 == `PMIE_PFX_HSINK) begin
        op = PMIE_OP_HSINK;
      end else if (pfx9 == `PMIE_PFX_SCS) begin
        op = PMIE_OP_SCS;
      end else if (pfx9 == `PMIE_PFX_T0L) begin
        op = PMIE_OP_T0L;
      end else if (pfx9 == `PMIE_PFX_T0H) begin
        op = PMIE_OP_T0H; // RL12
      end else if (pfx9 == `PMIE_PFX_T1L) begin
        op = PMIE_OP_T1L;
      end else if (i_instr[`PMIE_OP_HI:`PMIE_IMM4_PFX_LO] == `PMIE_PFX_WAKE) begin
        op = PMIE_OP_WAKE;
      end else if (i_instr[`PMIE_OP_HI:`PMIE_IMM8_PFX_LO] == `PMIE_PFX_T0IMM) begin
        op = PMIE_OP_T0IMM;
      end else if (i_instr[`PMIE_OP_HI:`PMIE_IMM8_PFX_LO] == `PMIE_PFX_T1IMM) begin
        op = PMIE_OP_T1IMM;
      end
    end
  end

  // Next-state for every latch; each instruction completes at the next edge
  always_comb begin
    bidir_nxt    = bidir_r;
    hsink_nxt    = hsink_r;
    scs_nxt      = scs_r;
    wake_nxt     = wake_r;
    t0_start_nxt = 1'b0;
    t1_start_nxt = 1'b0;
    t0_load_nxt  = t0_load_r;
    t1_load_nxt  = t1_load_r;
    t0_lo_nxt    = t0_lo_r;
    t0_hi_nxt    = t0_hi_r;
    t1_lo_nxt    = t1_lo_r;
    case (op)
      PMIE_OP_BIDIR2: begin
        bidir_nxt = src_nib; // RL1
      end
      PMIE_OP_HSINK: begin
        hsink_nxt = src_nib; // RL2
      end
      PMIE_OP_SCS: begin
        // Single-clock parts keep their fixed clocking
        if (i_dual_clock_opt) begin
          scs_nxt = i_instr[`PMIE_IMM4_HI:0]; // RL3
        end
      end
      PMIE_OP_WAKE: begin
        wake_nxt = i_instr[`PMIE_IMM4_HI:0]; // RL7
      end
      PMIE_OP_T0IMM: begin
        t0_load_nxt  = i_instr[`PMIE_IMM8_HI:0]; // RL8
        t0_start_nxt = 1'b1; // RL8
      end
      PMIE_OP_T1IMM: begin
        t1_load_nxt  = i_instr[`PMIE_IMM8_HI:0]; // RL9
        t1_start_nxt = 1'b1; // RL9
      end
      PMIE_OP_T0L: begin
        t0_lo_nxt = src_nib; // RL10
      end
      PMIE_OP_T0H: begin
        t0_hi_nxt = src_nib; // RL11
      end
      PMIE_OP_T1L: begin
        t1_lo_nxt = src_nib; // RL13
      end
      default: begin
      end
    endcase
    // No instruction loads the high nibble of timer one preset; held at zero here
    t0_pre_nxt = {t0_hi_nxt, t0_lo_nxt}; // RL15
    t1_pre_nxt = {`PMIE_RST_NIB, t1_lo_nxt}; // RL15
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bidir_r    <= `PMIE_RST_NIB;
      hsink_r    <= `PMIE_RST_NIB;
      scs_r      <= `PMIE_RST_SCS;
      wake_r     <= `PMIE_RST_NIB;
      t0_start_r <= 1'b0;
      t1_start_r <= 1'b0;
      t0_load_r  <= `PMIE_RST_BYTE;
      t1_load_r  <= `PMIE_RST_BYTE;
      t0_lo_r    <= `PMIE_RST_NIB;
      t0_hi_r    <= `PMIE_RST_NIB;
      t1_lo_r    <= `PMIE_RST_NIB;
      t0_pre_r   <= `PMIE_RST_BYTE;
      t1_pre_r   <= `PMIE_RST_BYTE;
    end else begin
      bidir_r    <= bidir_nxt;
      hsink_r    <= hsink_nxt;
      scs_r      <= scs_nxt;
      wake_r     <= wake_nxt;
      t0_start_r <= t0_start_nxt;
      t1_start_r <= t1_start_nxt;
      t0_load_r  <= t0_load_nxt;
      t1_load_r  <= t1_load_nxt;
      t0_lo_r    <= t0_lo_nxt;
      t0_hi_r    <= t0_hi_nxt;
      t1_lo_r    <= t1_lo_nxt;
      t0_pre_r   <= t0_pre_nxt;
      t1_pre_r   <= t1_pre_nxt;
    end
  end

  assign o_bidir_port_two        = bidir_r;
  assign o_high_sink_output_port = hsink_r;
  assign o_sub_osc_sel           = scs_r[`PMIE_SCS_SUB_BIT]; // RL4
  assign o_main_osc_stop         = scs_r[`PMIE_SCS_STOP_BIT]; // RL5
  assign o_div1_13_stage         = scs_r[`PMIE_SCS_DIV13_BIT]; // RL6
  assign o_stop_wake_enable_mask = wake_r;
  assign o_timer_zero_start      = t0_start_r;
  assign o_timer_zero_load       = t0_load_r;
  assign o_timer_one_start       = t1_start_r;
  assign o_timer_one_load        = t1_load_r;
  assign o_timer_zero_preset     = t0_pre_r;
  assign o_timer_one_preset      = t1_pre_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  AST_BIDIR_COPY: assert property ((op == PMIE_OP_BIDIR2) |=> // RL1
    o_bidir_port_two == $past(src_nib))
    else $error("bidir port two not loaded from RAM");
  AST_HSINK_COPY: assert property ((op == PMIE_OP_HSINK) |=> // RL2
    o_high_sink_output_port == $past(src_nib))
    else $error("high sink port not loaded from RAM");
  AST_SCS_GATED: assert property ((op == PMIE_OP_SCS && !i_dual_clock_opt) |=> // RL3
    $stable({o_sub_osc_sel, o_main_osc_stop, o_div1_13_stage}))
    else $error("clock select changed without dual-clock option");
  AST_SCS_BITS: assert property ((op == PMIE_OP_SCS && i_dual_clock_opt) |=> // RL4
    o_sub_osc_sel == $past(i_instr[0]) && o_main_osc_stop == $past(i_instr[1])
    && o_div1_13_stage == $past(i_instr[3]))
    else $error("clock select bits wrong");
  AST_WAKE_MASK: assert property ((op == PMIE_OP_WAKE) |=> // RL7
    o_stop_wake_enable_mask == $past(i_instr[3:0]))
    else $error("wake mask not loaded");
  AST_T0_START: assert property ((op == PMIE_OP_T0IMM) |=> // RL8
    o_timer_zero_start && o_timer_zero_load == $past(i_instr[7:0]))
    else $error("timer zero start wrong");
  // Back-to-back loads legally keep the start high, so the pulse end is its own check
  AST_T0_PULSE: assert property ((op != PMIE_OP_T0IMM) |=> !o_timer_zero_start) // RL8
    else $error("timer zero start without load");
  AST_T1_START: assert property ((op == PMIE_OP_T1IMM) |=> // RL9
    o_timer_one_start && o_timer_one_load == $past(i_instr[7:0]))
    else $error("timer one start wrong");
  AST_T1_PULSE: assert property ((op != PMIE_OP_T1IMM) |=> !o_timer_one_start) // RL9
    else $error("timer one start without load");
  AST_T0_PRESET: assert property ((op == PMIE_OP_T0H) |=> // RL11
    o_timer_zero_preset[7:4] == $past(src_nib)
    && o_timer_zero_preset[3:0] == $past(o_timer_zero_preset[3:0]))
    else $error("timer zero high preset wrong");
  AST_T0L_PRESET: assert property ((op == PMIE_OP_T0L) |=> // RL10
    o_timer_zero_preset == {$past(o_timer_zero_preset[7:4]), $past(src_nib)})
    else $error("timer zero low preset wrong");
  AST_T1L_PRESET: assert property ((op == PMIE_OP_T1L) |=> // RL13
    o_timer_one_preset[3:0] == $past(src_nib))
    else $error("timer one low preset wrong");

  COV_SCS_WRITE: cover property (op == PMIE_OP_SCS && i_dual_clock_opt ##1 o_main_osc_stop);
  COV_T0_SEQ: cover property (op == PMIE_OP_T0L ##1 op == PMIE_OP_T0H);
  COV_B2B_START: cover property (op == PMIE_OP_T0IMM ##1 op == PMIE_OP_T0IMM);
endmodule // pmie_top

// file: sim/test_pmie_top.sv
// Self-checking bench for the move instruction executor
`timescale 1ns/1ps
`include "pmie_defs.svh"
module test_pmie_top;
  import pmie_pkg::*;
  logic        i_clk            = 1'b0;
  logic        i_rst_b          = 1'b0;
  logic        i_instr_valid    = 1'b0;
  pmie_instr_t i_instr          = 16'h0000;
  logic        i_dual_clock_opt = 1'b0;
  logic        i_ram_we         = 1'b0;
  pmie_addr_t  i_ram_waddr      = 7'h00;
  pmie_nib_t   i_ram_wdata      = 4'h0;
  pmie_nib_t   o_bidir_port_two, o_high_sink_output_port, o_stop_wake_enable_mask;
  logic        o_sub_osc_sel, o_main_osc_stop, o_div1_13_stage;
  logic        o_timer_zero_start, o_timer_one_start;
  pmie_byte_t  o_timer_zero_load, o_timer_one_load, o_timer_zero_preset, o_timer_one_preset;
  int          n_errors  = 0;
  int          cmp_count = 0;
  pmie_addr_t  addrs [3] = '{7'h00, 7'h7f, 7'h35};
  pmie_nib_t   datas [3] = '{4'ha, 4'h5, 4'hc};

  pmie_top pmie_top_i (
    .i_clk, .i_rst_b, .i_instr_valid, .i_instr, .i_dual_clock_opt,
    .i_ram_we, .i_ram_waddr, .i_ram_wdata, .o_bidir_port_two, .o_high_sink_output_port,
    .o_sub_osc_sel, .o_main_osc_stop, .o_div1_13_stage, .o_stop_wake_enable_mask,
    .o_timer_zero_start, .o_timer_zero_load, .o_timer_one_start, .o_timer_one_load,
    .o_timer_zero_preset, .o_timer_one_preset
  );

  always #2.5 i_clk = ~i_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input pmie_addr_t a, input pmie_nib_t d);
    @(posedge i_clk);
    i_ram_we    <= 1'b1;
    i_ram_waddr <= a;
    i_ram_wdata <= d;
    @(posedge i_clk);
    i_ram_we <= 1'b0;
  endtask

  // One instruction, then look just after the edge that takes it
  task automatic ex(input pmie_instr_t w);
    @(posedge i_clk);
    i_instr_valid <= 1'b1;
    i_instr       <= w;
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    #1;
  endtask

  task automatic chk_zero();
    chk({o_bidir_port_two, o_high_sink_output_port}, 8'h00);
    chk({o_stop_wake_enable_mask, o_sub_osc_sel, o_main_osc_stop, o_div1_13_stage}, 8'h00);
    chk({6'h00, o_timer_zero_start, o_timer_one_start}, 8'h00);
    chk(o_timer_zero_load | o_timer_one_load, 8'h00);
    chk(o_timer_zero_preset | o_timer_one_preset, 8'h00);
  endtask

  // Address extremes catch a truncated address field
  task automatic t_ram_moves();
    for (int i = 0; i < 3; i++) begin
      wr(addrs[i], datas[i]);
      wr(~addrs[i], ~datas[i]);
      ex({`PMIE_PFX_BIDIR2, addrs[i]});
      chk({4'h0, o_bidir_port_two}, {4'h0, datas[i]});
      ex({`PMIE_PFX_HSINK, ~addrs[i]});
      chk({4'h0, o_high_sink_output_port}, {4'h0, ~datas[i]});
      chk({4'h0, o_bidir_port_two}, {4'h0, datas[i]});
      ex({`PMIE_PFX_T0L, addrs[i]});
      ex({`PMIE_PFX_T0H, ~addrs[i]});
      chk(o_timer_zero_preset, {~datas[i], datas[i]});
      ex({`PMIE_PFX_T1L, ~addrs[i]});
      chk(o_timer_one_preset, {4'h0, ~datas[i]});
    end
    $display("test ram moves done");
  endtask

  task automatic t_clock_select();
    ex({`PMIE_PFX_SCS, 3'h0, 4'hf});
    chk({5'h00, o_div1_13_stage, o_main_osc_stop, o_sub_osc_sel}, 8'h00);
    @(posedge i_clk);
    i_dual_clock_opt <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      ex({`PMIE_PFX_SCS, 3'h0, 4'(k)});
      chk({5'h00, o_div1_13_stage, o_main_osc_stop, o_sub_osc_sel},
          {5'h00, k[3], k[1], k[0]});
    end
    @(posedge i_clk);
    i_dual_clock_opt <= 1'b0;
    ex({`PMIE_PFX_SCS, 3'h0, 4'h0});
    chk({5'h00, o_div1_13_stage, o_main_osc_stop, o_sub_osc_sel}, 8'h07);
    $display("test clock select done");
  endtask

  task automatic t_wake();
    pmie_nib_t masks [4] = '{4'h1, 4'h8, 4'h6, 4'h0};
    for (int k = 0; k < 4; k++) begin
      ex({`PMIE_PFX_WAKE, masks[k]});
      chk({4'h0, o_stop_wake_enable_mask}, {4'h0, masks[k]});
    end
    $display("test wake mask done");
  endtask

  // Back-to-back loads; a start pulse lasts one cycle unless the same timer loads again
  task automatic t_timers();
    pmie_byte_t v [2] = '{8'ha5, 8'hff};
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_instr_valid <= 1'b1;
      i_instr       <= {`PMIE_PFX_T0IMM, v[k]};
      @(posedge i_clk);
      i_instr <= {`PMIE_PFX_T1IMM, ~v[k]};
      #1;
      chk({6'h00, o_timer_zero_start, o_timer_one_start}, 8'h02);
      chk(o_timer_zero_load, v[k]);
      @(posedge i_clk);
      i_instr_valid <= 1'b0;
      #1;
      chk({6'h00, o_timer_zero_start, o_timer_one_start}, 8'h01);
      chk(o_timer_one_load, ~v[k]);
      @(posedge i_clk);
      #1;
      chk({6'h00, o_timer_zero_start, o_timer_one_start}, 8'h00);
      chk(o_timer_zero_load, v[k]);
    end
    // Same timer twice in a row: start stays high, second value wins
    @(posedge i_clk);
    i_instr_valid <= 1'b1;
    i_instr       <= {`PMIE_PFX_T0IMM, 8'h3c};
    @(posedge i_clk);
    i_instr <= {`PMIE_PFX_T0IMM, 8'hc3};
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    #1;
    chk({7'h00, o_timer_zero_start}, 8'h01);
    chk(o_timer_zero_load, 8'hc3);
    @(posedge i_clk);
    #1;
    chk({7'h00, o_timer_zero_start}, 8'h00);
    $display("test timers done");
  endtask

  // A neighbouring opcode must leave the presets alone
  task automatic t_unrecognised();
    pmie_byte_t p0;
    p0 = o_timer_zero_preset;
    ex({9'h02b, 7'h00});
    ex(16'hffff);
    chk(o_timer_zero_preset, p0);
    chk({4'h0, o_timer_one_preset[7:4]}, 8'h00);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    #1;
    chk_zero();
    $display("test unrecognised and reset done");
  endtask

  initial begin
    #20000;
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    #1;
    chk_zero();
    t_ram_moves();
    t_clock_select();
    t_wake();
    t_timers();
    t_unrecognised();
    stop_test();
  end
endmodule // test_pmie_top
